/* pkg/gws_consts.svh */
`ifndef GWS_CONSTS_SVH
`define GWS_CONSTS_SVH
// ==========================================
// Widths
`define GWS_PIN_W 48
`define GWS_SYNC_W 51
// ==========================================
// Register offsets (bank or port index is added to a base)
`define GWS_OFF_WST 8'h10
`define GWS_OFF_WEN 8'h18
`define GWS_OFF_SST 8'h20
`define GWS_OFF_SEN 8'h28
`define GWS_OFF_MISC 8'h30
`define GWS_OFF_EESEL 8'h31
`define GWS_OFF_ALT 8'h32
`define GWS_OFF_SMICFG 8'h33
`define GWS_OFF_WAKE_GEN 8'h34
`define GWS_OFF_DIR 8'h40
`define GWS_OFF_POL 8'h48
`define GWS_OFF_DATA 8'h50
`define GWS_OFF_IND_A 8'h5D
`define GWS_OFF_IND_B 8'h5E
// ==========================================
// Reset values
`define GWS_RST_DIR 8'hFF
`define GWS_RST_DIR_P3 8'hF3
`define GWS_RST_DIR_P5 8'hF7
`define GWS_RST_SMICFG 8'h80
`define GWS_RST_OE 48'h0008000C0000
// ==========================================
// Field positions
`define GWS_SEN2_PIN 7
`define GWS_SEN2_IRQ 6
`define GWS_SEN2_WAKE 5
`define GWS_CFG_POL 1
`define GWS_CFG_TYPE 7
`define GWS_WST3_DEVINT 3
`define GWS_ALT_P4B3 0
`define GWS_ALT_IND_A 1
`define GWS_ALT_IND_B 2
`define GWS_GEN_EN 0
// ==========================================
// Timing: 32 kHz ticks per blink half period
`define GWS_BLINK_HALF 16384
`define GWS_FAST_DIV 4
`define GWS_WARM 2'h3
`endif

/* pkg/gws_pkg.sv */
// ==========================================
// Types shared by the event logic
package gws_pkg;
  // Indicator mode field of the indicator control registers
  typedef enum logic [1:0] {
    GWS_IND_OFF = 2'h0,
    GWS_IND_BLINK = 2'h1,
    GWS_IND_ON = 2'h2,
    GWS_IND_FAST = 2'h3
  } gws_ind_mode_t;
endpackage : gws_pkg

/* hdl/gws_sync.sv */
`timescale 1ns/100ps
// ==========================================
// Two flop synchroniser for a vector of levels
module gws_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] q1_reg; // First stage, read only by second stage
  logic [W-1:0] q2_reg; // Second stage

  // Both stages clear on reset
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      q1_reg <= '0;
      q2_reg <= '0;
    end else begin
      q1_reg <= d_in;
      q2_reg <= q1_reg;
    end
  end

  assign q_out = q2_reg;
endmodule : gws_sync

/* hdl/gws_indicator.sv */
`timescale 1ns/100ps
`include "gws_consts.svh"
// ==========================================
// Indicator driver paced by 32 kHz ticks
module gws_indicator #(
  parameter int HALF_TICKS = `GWS_BLINK_HALF
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic tick_in,
  input wire logic [1:0] mode_in,
  output logic lit_out
);
  localparam int CW = $clog2(HALF_TICKS + 1);
  logic [CW-1:0] cnt_reg; // Ticks in current half period
  logic phase_reg; // Blink phase
  logic [CW-1:0] lim; // Ticks per half period

  // Fast mode uses a shorter half period
  assign lim = (gws_pkg::gws_ind_mode_t'(mode_in) == gws_pkg::GWS_IND_FAST) ?
               CW'(HALF_TICKS / `GWS_FAST_DIV) : CW'(HALF_TICKS);

  // Only a 32 kHz tick advances the blink
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cnt_reg <= '0;
      phase_reg <= 1'b0;
    end else if (tick_in) begin
      if (cnt_reg >= lim - CW'(1)) begin
        cnt_reg <= '0;
        phase_reg <= ~phase_reg;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  // Mode selects off, on or blink phase
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      lit_out <= 1'b0;
    end else begin
      unique case (gws_pkg::gws_ind_mode_t'(mode_in))
        gws_pkg::GWS_IND_OFF: lit_out <= 1'b0;
        gws_pkg::GWS_IND_ON: lit_out <= 1'b1;
        gws_pkg::GWS_IND_BLINK: lit_out <= phase_reg;
        gws_pkg::GWS_IND_FAST: lit_out <= phase_reg;
      endcase
    end
  end

  property p_no_tick_hold;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      !tick_in |=> $stable(phase_reg);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("blink phase moved without a 32 kHz tick");
endmodule : gws_indicator

/* hdl/gws_event_top.sv */
`timescale 1ns/100ps
`include "gws_consts.svh"
// ==========================================
// Pin wake and system management event logic
module gws_event_top #(
  parameter int BLINK_HALF = `GWS_BLINK_HALF
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic main_power_ok_in,
  input wire logic clk32k_in,
  input wire logic [`GWS_PIN_W-1:0] gpio_pin_in,
  input wire logic fan_speed_input_a_in,
  input wire logic fan_speed_input_b_in,
  input wire logic parallel_port_request_in,
  input wire logic serial_port_a_request_in,
  input wire logic serial_port_b_request_in,
  input wire logic floppy_request_in,
  input wire logic mouse_request_in,
  input wire logic keyboard_request_in,
  input wire logic infrared_request_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [`GWS_PIN_W-1:0] gpio_pin_out,
  output logic [`GWS_PIN_W-1:0] gpio_pin_oe_out,
  output logic group_sysmgmt_pin_n_out,
  output logic group_sysmgmt_pin_oe_out,
  output logic wake_event_pin_n_out,
  output logic wake_event_pin_oe_out,
  output logic serial_irq2_out,
  output logic group_sysmgmt_internal_n_out
);
  // ==========================================
  // Helpers
  // Vector position of a port bit
  function automatic int pos(input int p, input int b);
    return (p - 1) * 8 + b;
  endfunction : pos

  // Position of the k-th either-edge pin
  function automatic int ee_pos(input int k);
    case (k)
      0: return pos(2, 1);
      1: return pos(2, 2);
      2: return pos(4, 1);
      3: return pos(4, 3);
      4: return pos(6, 0);
      default: return pos(6, 1);
    endcase
  endfunction : ee_pos

  // Write-one-to-clear with set winning
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic hit,
                                     input logic [7:0] wd, input logic [7:0] ev);
    return (cur & ~(hit ? wd : 8'h00)) | ev;
  endfunction : w1c

  // ==========================================
  // Registers
  logic [7:0] dir_reg [1:6]; // 1 = input
  logic [7:0] pol_reg [1:6]; // 1 = inverted
  logic [7:0] dat_reg [1:6]; // Output data
  logic [7:0] wst_reg [2:5]; // Wake status banks
  logic [7:0] wen_reg [2:5]; // Wake enable banks
  logic [7:0] sst_reg [3:5]; // SMI status banks
  logic [7:0] sen_reg [1:5]; // SMI enable banks
  logic [7:0] misc_reg; // Either-edge status
  logic [7:0] eesel_reg; // Either-edge mode select
  logic [7:0] alt_reg; // Alternate function selects
  logic [7:0] smicfg_reg; // SMI pin config
  logic [7:0] gen_reg; // Global wake enable
  logic [7:0] ind_a_reg; // Indicator A control
  logic [7:0] ind_b_reg; // Indicator B control
  logic [`GWS_SYNC_W-1:0] sync_w; // Synchronised inputs
  logic [`GWS_SYNC_W-1:0] prev_reg; // Previous synchronised inputs
  logic [1:0] warm_reg; // Suppresses edges right after reset
  logic warm; // Edge detection allowed
  logic [`GWS_PIN_W-1:0] ee_v; // Either-edge mode per pin
  logic [`GWS_PIN_W-1:0] ev_all; // Status events per pin
  logic [7:0] ev_b [1:6]; // Events per port
  logic [7:0] wev [2:5]; // Wake bank events
  logic [7:0] sev [3:5]; // SMI bank events
  logic [7:0] misc_ev; // Misc bank events
  logic [6:0] func_vec; // Functional block requests
  logic [1:0] fan_ev; // Tachometer events
  logic grp_c; // Group SMI
  logic wake_c; // Wake event
  logic smi_act; // Group SMI allowed onto its pin
  logic smi_lvl; // SMI pin level before the driver type
  logic tick32; // 32 kHz rising edge
  logic lit_a, lit_b; // Indicator levels
  logic [7:0] rd_c; // Read mux
  logic [`GWS_PIN_W-1:0] gp_out_c, gp_oe_c; // Pin drive

  // ==========================================
  // Input synchronisation and edge detection
  gws_sync #(.W(`GWS_SYNC_W)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .d_in({clk32k_in, fan_speed_input_b_in, fan_speed_input_a_in, gpio_pin_in}),
    .q_out(sync_w)
  );

  // Previous sample and warm-up count
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      prev_reg <= '0;
      warm_reg <= 2'h0;
    end else begin
      prev_reg <= sync_w;
      if (warm_reg != `GWS_WARM) begin
        warm_reg <= warm_reg + 2'h1;
      end
    end
  end

  assign warm = (warm_reg == `GWS_WARM);
  assign tick32 = warm & sync_w[`GWS_SYNC_W-1] & ~prev_reg[`GWS_SYNC_W-1];
  assign fan_ev = {2{warm}} & sync_w[`GWS_PIN_W+:2] & ~prev_reg[`GWS_PIN_W+:2];
  assign func_vec = {infrared_request_in, keyboard_request_in, mouse_request_in,
                     floppy_request_in, serial_port_b_request_in,
                     serial_port_a_request_in, parallel_port_request_in};

  // Per-pin events
  always_comb begin
    logic chg;
    logic pe;
    chg = 1'b0;
    pe = 1'b0;
    ee_v = '0;
    misc_ev = 8'h00;
    for (int k = 0; k < 6; k++) begin
      ee_v[ee_pos(k)] = eesel_reg[k];
      misc_ev[k] = warm & (sync_w[ee_pos(k)] ^ prev_reg[ee_pos(k)]);
    end
    for (int i = 0; i < `GWS_PIN_W; i++) begin
      chg = sync_w[i] ^ prev_reg[i];
      // Polarity picks the edge, rising by default
      pe = pol_reg[i / 8 + 1][i % 8] ? (prev_reg[i] & ~sync_w[i]) :
           (sync_w[i] & ~prev_reg[i]);
      if (ee_v[i]) begin
        ev_all[i] = warm & chg;
      end else begin
        ev_all[i] = warm & pe & dir_reg[i / 8 + 1][i % 8];
      end
    end
    for (int p = 1; p <= 6; p++) begin
      ev_b[p] = ev_all[pos(p, 0)+:8];
    end
  end

  // Bank mapping of pin events
  always_comb begin
    wev[2] = ev_b[1];
    wev[3] = {ev_b[2][7:4], grp_c & sen_reg[2][`GWS_SEN2_WAKE], ev_b[2][2:0]};
    wev[4] = {ev_b[6][1:0], ev_b[4][3], ev_b[4][1], ev_b[3][3:0]};
    wev[5] = ev_b[5];
    sev[3] = {1'b0, ev_b[2][6:4], ev_b[6][0], ev_b[2][2:0]};
    sev[4] = {ev_b[6][1], ev_b[4][3:1], ev_b[3][3:0]};
    sev[5] = {2'b00, fan_ev, ev_b[5][7:4]};
  end

  // ==========================================
  // Status registers
  // Events set, write one clears, set wins over clear
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      for (int b = 2; b <= 5; b++) wst_reg[b] <= 8'h00;
      for (int b = 3; b <= 5; b++) sst_reg[b] <= 8'h00;
      misc_reg <= 8'h00;
    end else begin
      for (int b = 2; b <= 5; b++) begin
        wst_reg[b] <= w1c(wst_reg[b], reg_wr_in && reg_addr_in == `GWS_OFF_WST + 8'(b),
                          reg_wdata_in, wev[b]);
      end
      for (int b = 3; b <= 5; b++) begin
        sst_reg[b] <= w1c(sst_reg[b], reg_wr_in && reg_addr_in == `GWS_OFF_SST + 8'(b),
                          reg_wdata_in, sev[b]);
      end
      misc_reg <= w1c(misc_reg, reg_wr_in && reg_addr_in == `GWS_OFF_MISC,
                      reg_wdata_in, misc_ev);
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      for (int p = 1; p <= 6; p++) begin
        dir_reg[p] <= (p == 3) ? `GWS_RST_DIR_P3 :
                      (p == 5) ? `GWS_RST_DIR_P5 : `GWS_RST_DIR;
        pol_reg[p] <= 8'h00;
        dat_reg[p] <= 8'h00;
      end
      for (int b = 2; b <= 5; b++) wen_reg[b] <= 8'h00;
      for (int b = 1; b <= 5; b++) sen_reg[b] <= 8'h00;
      eesel_reg <= 8'h00;
      alt_reg <= 8'h00;
      smicfg_reg <= `GWS_RST_SMICFG;
      gen_reg <= 8'h00;
      ind_a_reg <= 8'h00;
      ind_b_reg <= 8'h00;
    end else if (reg_wr_in) begin
      for (int p = 1; p <= 6; p++) begin
        if (reg_addr_in == `GWS_OFF_DIR + 8'(p)) dir_reg[p] <= reg_wdata_in;
        if (reg_addr_in == `GWS_OFF_POL + 8'(p)) pol_reg[p] <= reg_wdata_in;
        if (reg_addr_in == `GWS_OFF_DATA + 8'(p)) dat_reg[p] <= reg_wdata_in;
      end
      for (int b = 2; b <= 5; b++) begin
        if (reg_addr_in == `GWS_OFF_WEN + 8'(b)) wen_reg[b] <= reg_wdata_in;
      end
      for (int b = 1; b <= 5; b++) begin
        if (reg_addr_in == `GWS_OFF_SEN + 8'(b)) sen_reg[b] <= reg_wdata_in;
      end
      if (reg_addr_in == `GWS_OFF_EESEL) eesel_reg <= reg_wdata_in;
      if (reg_addr_in == `GWS_OFF_ALT) alt_reg <= reg_wdata_in;
      if (reg_addr_in == `GWS_OFF_SMICFG) smicfg_reg <= reg_wdata_in;
      if (reg_addr_in == `GWS_OFF_WAKE_GEN) gen_reg <= reg_wdata_in;
      if (reg_addr_in == `GWS_OFF_IND_A) ind_a_reg <= reg_wdata_in;
      if (reg_addr_in == `GWS_OFF_IND_B) ind_b_reg <= reg_wdata_in;
    end
  end

  // ==========================================
  // Read path
  // Data reads show pin level through polarity, or last written value
  always_comb begin
    logic [7:0] din;
    din = 8'h00;
    rd_c = 8'h00;
    for (int p = 1; p <= 6; p++) begin
      din = dir_reg[p] | ee_v[pos(p, 0)+:8];
      if (reg_addr_in == `GWS_OFF_DIR + 8'(p)) rd_c = dir_reg[p];
      if (reg_addr_in == `GWS_OFF_POL + 8'(p)) rd_c = pol_reg[p];
      if (reg_addr_in == `GWS_OFF_DATA + 8'(p)) begin
        rd_c = (din & (sync_w[pos(p, 0)+:8] ^ pol_reg[p])) | (~din & dat_reg[p]);
      end
    end
    for (int b = 2; b <= 5; b++) begin
      if (reg_addr_in == `GWS_OFF_WST + 8'(b)) rd_c = wst_reg[b];
      if (reg_addr_in == `GWS_OFF_WEN + 8'(b)) rd_c = wen_reg[b];
    end
    for (int b = 3; b <= 5; b++) begin
      if (reg_addr_in == `GWS_OFF_SST + 8'(b)) rd_c = sst_reg[b];
    end
    for (int b = 1; b <= 5; b++) begin
      if (reg_addr_in == `GWS_OFF_SEN + 8'(b)) rd_c = sen_reg[b];
    end
    if (reg_addr_in == `GWS_OFF_SST + 8'h01) rd_c = {1'b0, func_vec};
    if (reg_addr_in == `GWS_OFF_MISC) rd_c = misc_reg;
    if (reg_addr_in == `GWS_OFF_EESEL) rd_c = eesel_reg;
    if (reg_addr_in == `GWS_OFF_ALT) rd_c = alt_reg;
    if (reg_addr_in == `GWS_OFF_SMICFG) rd_c = smicfg_reg;
    if (reg_addr_in == `GWS_OFF_WAKE_GEN) rd_c = gen_reg;
    if (reg_addr_in == `GWS_OFF_IND_A) rd_c = ind_a_reg;
    if (reg_addr_in == `GWS_OFF_IND_B) rd_c = ind_b_reg;
  end

  // Read data held until next read
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_c;
    end
  end

  // ==========================================
  // Group SMI and wake
  // Enabled functional requests and enabled pin statuses
  assign grp_c = (|(sen_reg[1][6:0] & func_vec)) |
                 (|(sst_reg[3] & sen_reg[3])) | (|(sst_reg[4] & sen_reg[4])) |
                 (|(sst_reg[5] & sen_reg[5]));
  assign wake_c = gen_reg[`GWS_GEN_EN] &
                  ((|(wst_reg[2] & wen_reg[2])) | (|(wst_reg[3] & wen_reg[3])) |
                   (|(wst_reg[4] & wen_reg[4])) | (|(wst_reg[5] & wen_reg[5])));

  // SMI routing to pin, IRQ2 and wake pin
  assign smi_act = grp_c & sen_reg[2][`GWS_SEN2_PIN];
  assign smi_lvl = smicfg_reg[`GWS_CFG_POL] ? smi_act : ~smi_act;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      group_sysmgmt_internal_n_out <= 1'b1;
      serial_irq2_out <= 1'b0;
      group_sysmgmt_pin_n_out <= 1'b0;
      group_sysmgmt_pin_oe_out <= 1'b0;
      wake_event_pin_n_out <= 1'b0;
      wake_event_pin_oe_out <= 1'b0;
    end else begin
      group_sysmgmt_internal_n_out <= ~grp_c;
      serial_irq2_out <= grp_c & sen_reg[2][`GWS_SEN2_IRQ];
      if (smicfg_reg[`GWS_CFG_TYPE]) begin
        // Open drain: pull low only
        group_sysmgmt_pin_n_out <= 1'b0;
        group_sysmgmt_pin_oe_out <= ~smi_lvl;
      end else begin
        group_sysmgmt_pin_n_out <= smi_lvl;
        group_sysmgmt_pin_oe_out <= 1'b1;
      end
      wake_event_pin_n_out <= 1'b0;
      wake_event_pin_oe_out <= wake_c;
    end
  end

  // ==========================================
  // Indicators
  gws_indicator #(.HALF_TICKS(BLINK_HALF)) u_ind_a (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick32),
    .mode_in(ind_a_reg[1:0]),
    .lit_out(lit_a)
  );

  gws_indicator #(.HALF_TICKS(BLINK_HALF)) u_ind_b (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick32),
    .mode_in(ind_b_reg[1:0]),
    .lit_out(lit_b)
  );

  // ==========================================
  // Pin drive
  always_comb begin
    for (int p = 1; p <= 6; p++) begin
      gp_out_c[pos(p, 0)+:8] = dat_reg[p] ^ pol_reg[p];
      gp_oe_c[pos(p, 0)+:8] = ~dir_reg[p] & ~ee_v[pos(p, 0)+:8];
    end
    if (!main_power_ok_in) begin
      // Standby: these pins fall back to plain outputs
      gp_out_c[pos(3, 2)] = dat_reg[3][2];
      gp_out_c[pos(3, 3)] = dat_reg[3][3];
      gp_out_c[pos(5, 3)] = dat_reg[5][3];
      gp_oe_c[pos(3, 2)] = 1'b1;
      gp_oe_c[pos(3, 3)] = 1'b1;
      gp_oe_c[pos(5, 3)] = 1'b1;
    end
    if (alt_reg[`GWS_ALT_P4B3]) gp_oe_c[pos(4, 3)] = 1'b0;
    if (alt_reg[`GWS_ALT_IND_A]) begin
      gp_out_c[pos(6, 0)] = lit_a;
      gp_oe_c[pos(6, 0)] = 1'b1;
    end
    if (alt_reg[`GWS_ALT_IND_B]) begin
      gp_out_c[pos(6, 1)] = lit_b;
      gp_oe_c[pos(6, 1)] = 1'b1;
    end
  end

  // Registered pin drive, low outputs after reset
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      gpio_pin_out <= '0;
      gpio_pin_oe_out <= `GWS_RST_OE;
    end else begin
      gpio_pin_out <= gp_out_c;
      gpio_pin_oe_out <= gp_oe_c;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_misc_edge;
    warm && (sync_w[pos(6, 0)] != prev_reg[pos(6, 0)]) |=> misc_reg[4];
  endproperty
  a_misc_edge: assert property (p_misc_edge)
    else $error("misc status missed an edge");

  property p_w1c;
    reg_wr_in && reg_addr_in == `GWS_OFF_MISC && reg_wdata_in[0] && !misc_ev[0]
      |=> !misc_reg[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear status");

  property p_sync_lat;
    $changed(gpio_pin_in[pos(2, 1)]) ##1 $stable(gpio_pin_in[pos(2, 1)])[*2] ##0 warm
      |=> misc_reg[0];
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("pin edge not seen three cycles later");

  property p_pin_gate;
    !$past(sen_reg[2][`GWS_SEN2_PIN]) && $stable(smicfg_reg) |->
      ((group_sysmgmt_pin_oe_out ? group_sysmgmt_pin_n_out : 1'b1) ==
       !smicfg_reg[`GWS_CFG_POL]);
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("SMI pin active while disabled");

  property p_irq2;
    serial_irq2_out |-> !group_sysmgmt_internal_n_out && $past(sen_reg[2][`GWS_SEN2_IRQ]);
  endproperty
  a_irq2: assert property (p_irq2)
    else $error("IRQ2 without group SMI");

  property p_devint;
    $past(grp_c && sen_reg[2][`GWS_SEN2_WAKE]) |-> wst_reg[3][`GWS_WST3_DEVINT];
  endproperty
  a_devint: assert property (p_devint)
    else $error("device interrupt wake status not set");

  property p_func;
    parallel_port_request_in && sen_reg[1][0] |=> !group_sysmgmt_internal_n_out;
  endproperty
  a_func: assert property (p_func)
    else $error("enabled request gave no group SMI");

  property p_wake_gate;
    wake_event_pin_oe_out |-> $past(gen_reg[`GWS_GEN_EN]);
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake driven with global enable off");

  property p_excl;
    !dir_reg[1][0] && !wst_reg[2][0] |=> !wst_reg[2][0];
  endproperty
  a_excl: assert property (p_excl)
    else $error("output pin set wake status");

  property p_rst_dir;
    !$past(rstn_in) |-> !dir_reg[3][2] && !dir_reg[3][3] && !dir_reg[5][3] &&
      !alt_reg[`GWS_ALT_P4B3] && gpio_pin_oe_out[pos(3, 2)] && !gpio_pin_out[pos(3, 2)];
  endproperty
  a_rst_dir: assert property (@(posedge ref_clk_in) p_rst_dir)
    else $error("reset pin setup wrong");

  c_misc: cover property (misc_ev[0]);
  c_smi_pin: cover property (group_sysmgmt_pin_oe_out && !group_sysmgmt_pin_n_out);
  c_wake: cover property (wake_event_pin_oe_out);
  c_irq2: cover property (serial_irq2_out);
endmodule : gws_event_top

/* tb/gws_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// Host chipset side: sees the event pins through pull-ups
module gws_host_model (
  input wire logic smi_n_in,
  input wire logic smi_oe_in,
  input wire logic wake_n_in,
  input wire logic wake_oe_in,
  output logic smi_wire_out,
  output logic wake_wire_out
);
  // A released pin rises to the pull-up level
  assign smi_wire_out = smi_oe_in ? smi_n_in : 1'b1;
  assign wake_wire_out = wake_oe_in ? wake_n_in : 1'b1;
endmodule : gws_host_model

/* tb/gpio_wake_smi_event_logic_tb_top.sv */
`timescale 1ns/100ps
`include "gws_consts.svh"
// ==========================================
// Bench for the pin event logic
module gpio_wake_smi_event_logic_tb_top;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [`GWS_PIN_W-1:0] pins = '0; // Pin levels
  logic [6:0] req = 7'h00; // Functional requests
  logic ck32 = 1'b0; // Slow blink clock, toggled by hand
  logic mpok = 1'b1; // Main power present
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [`GWS_PIN_W-1:0] pin_o, pin_oe;
  logic smi_n, smi_oe, wake_n, wake_oe, irq2, int_n, smi_w, wake_w;
  int failures = 0;
  int n_tests = 0;
  gws_event_top #(.BLINK_HALF(4)) u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .main_power_ok_in(mpok), .clk32k_in(ck32), .gpio_pin_in(pins),
    .fan_speed_input_a_in(1'b0), .fan_speed_input_b_in(1'b0),
    .parallel_port_request_in(req[0]), .serial_port_a_request_in(req[1]),
    .serial_port_b_request_in(req[2]), .floppy_request_in(req[3]),
    .mouse_request_in(req[4]), .keyboard_request_in(req[5]), .infrared_request_in(req[6]),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .gpio_pin_out(pin_o), .gpio_pin_oe_out(pin_oe),
    .group_sysmgmt_pin_n_out(smi_n), .group_sysmgmt_pin_oe_out(smi_oe),
    .wake_event_pin_n_out(wake_n), .wake_event_pin_oe_out(wake_oe),
    .serial_irq2_out(irq2), .group_sysmgmt_internal_n_out(int_n));
  gws_host_model u_host (.smi_n_in(smi_n), .smi_oe_in(smi_oe), .wake_n_in(wake_n),
    .wake_oe_in(wake_oe), .smi_wire_out(smi_w), .wake_wire_out(wake_w));
  // Clock of 5 ns period
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // Waits n edges, then steps off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cyc
  // Compares one value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  // Register write, strobe dropped for one idle edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_reg
  // Register read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk("reg", e, rdata);
    cyc(1);
  endtask : rd_chk
  // Reset state of pins and configuration
  task automatic t_reset;
    chk("oe p3", 8'h0C, pin_oe[23:16]);
    chk("oe p5", 8'h08, pin_oe[39:32]);
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h33, 8'h80);
    $display("t_reset done");
  endtask : t_reset
  // Miscellaneous status on both edges, write one clears
  task automatic t_misc;
    pins[9] = 1'b1;
    cyc(6);
    rd_chk(8'h30, 8'h01);
    rd_chk(8'h13, 8'h02);
    wr_reg(8'h30, 8'h00);
    rd_chk(8'h30, 8'h01);
    wr_reg(8'h30, 8'h01);
    rd_chk(8'h30, 8'h00);
    pins[9] = 1'b0;
    cyc(6);
    rd_chk(8'h30, 8'h01);
    $display("t_misc done");
  endtask : t_misc
  // Falling edge on an either-edge pin reaches the SMI pin
  task automatic t_either_edge_irq;
    wr_reg(8'h31, 8'h01);
    wr_reg(8'h2B, 8'h02);
    wr_reg(8'h23, 8'hFF);
    wr_reg(8'h2A, 8'h80);
    chk("smi idle", 8'h01, {7'h00, smi_w});
    pins[9] = 1'b1;
    cyc(6);
    wr_reg(8'h23, 8'h02);
    pins[9] = 1'b0;
    cyc(6);
    rd_chk(8'h23, 8'h02);
    chk("smi pin", 8'h00, {7'h00, smi_w});
    wr_reg(8'h2A, 8'h00);
    cyc(3);
    chk("smi off", 8'h01, {7'h00, smi_w});
    wr_reg(8'h23, 8'hFF);
    $display("t_either_edge_irq done");
  endtask : t_either_edge_irq
  // Each functional source gated by its enable
  task automatic t_func;
    wr_reg(8'h2A, 8'h40);
    for (int i = 0; i < 7; i++) begin
      req = 7'h01 << i;
      wr_reg(8'h29, ~(8'h01 << i) & 8'h7F);
      cyc(4);
      chk("grp off", 8'h01, {7'h00, int_n});
      wr_reg(8'h29, 8'h01 << i);
      cyc(4);
      chk("grp on", 8'h00, {7'h00, int_n});
      chk("irq2", 8'h01, {7'h00, irq2});
      chk("pin off", 8'h01, {7'h00, smi_w});
    end
    $display("t_func done");
  endtask : t_func
  // Group SMI routed into the wake path
  task automatic t_wake;
    wr_reg(8'h2A, 8'h20);
    wr_reg(8'h13, 8'hFF);
    rd_chk(8'h13, 8'h08);
    wr_reg(8'h1B, 8'h08);
    wr_reg(8'h34, 8'h01);
    cyc(5);
    chk("wake", 8'h00, {7'h00, wake_w});
    $display("t_wake done");
  endtask : t_wake
  // Indicator drive and pacing, standby fallback, output pin exclusion
  task automatic t_ind;
    wr_reg(8'h32, 8'h02);
    wr_reg(8'h5D, 8'h02);
    cyc(3);
    chk("led on", 8'h03, {6'h00, pin_oe[40], pin_o[40]});
    wr_reg(8'h5D, 8'h01);
    cyc(3);
    chk("led no tick", 8'h02, {6'h00, pin_oe[40], pin_o[40]});
    repeat (4) begin
      ck32 = 1'b1;
      cyc(3);
      ck32 = 1'b0;
      cyc(3);
    end
    chk("led blink", 8'h03, {6'h00, pin_oe[40], pin_o[40]});
    wr_reg(8'h43, 8'hFF);
    wr_reg(8'h4B, 8'hFF);
    mpok = 1'b0;
    cyc(3);
    chk("standby", 8'h0C, {4'h0, pin_oe[19:18], pin_o[19:18]});
    mpok = 1'b1;
    cyc(3);
    chk("main back", 8'h03, {4'h0, pin_oe[19:18], pin_o[19:18]});
    wr_reg(8'h41, 8'hFE);
    wr_reg(8'h12, 8'hFF);
    pins[0] = 1'b1;
    cyc(6);
    rd_chk(8'h12, 8'h00);
    $display("t_ind done");
  endtask : t_ind
  // Prints counts and verdict, ends the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    cyc(16);
    rstn_in = 1'b1;
    cyc(4);
    t_reset();
    t_misc();
    t_either_edge_irq();
    t_func();
    t_wake();
    t_ind();
    report_and_stop();
  end
endmodule : gpio_wake_smi_event_logic_tb_top
